/* core/spc_config_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module spc_config_regs
  import spc_pkg::*;
#(
  parameter logic [7:0]  REVISION    = 8'h5a, // arbitrary value
  parameter logic [15:0] FAMILY_CODE = 16'hc3e7 // arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic            regRdValid,
  input  wire logic       reloadEnable,
  input  wire logic       reloadDone,
  input  wire logic       nvSave,
  output logic      [7:0] nvSaveData,
  output logic            nvSaveValid,
  output logic            fourWireSelect,
  output logic            lsbFirst,
  output logic            addrIncrement,
  output logic            softResetPulse,
  output logic            reloadStart,
  output logic            reloadBusy,
  output logic      [15:0] scratchActive
);

  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  logic rstMeta_reg;
  logic rstSync_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    spc_state_t  state;
    logic        fourWire;
    logic        lsbFirst;
    logic        rbSel;
    logic [15:0] scrBuf;
    logic [15:0] scrAct;
    logic [7:0]  revAct;
    logic [15:0] famAct;
    logic [7:0]  rdData;
    logic        rdValid;
    logic [7:0]  nvData;
    logic        nvValid;
    logic        rstPulse;
    logic        reloadGo;
  } spc_regs_t;

  spc_regs_t r_reg;
  spc_regs_t r_next;

  function automatic logic [7:0] setupByte(input logic fw, input logic lsb);
    setupByte = SPC_RST_ZERO;
    setupByte[SPC_BIT_FOURWIRE] = fw;
    setupByte[SPC_BIT_LSBFIRST] = lsb;
  endfunction

  function automatic logic [7:0] lowBit(input logic b);
    lowBit = SPC_RST_ZERO;
    lowBit[0] = b;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] scrView;
    scrView = 16'h0000;
    r_next = r_reg;
    r_next.rdValid = 1'b0;
    r_next.nvValid = 1'b0;
    r_next.rstPulse = 1'b0;
    r_next.reloadGo = 1'b0;
    unique case (r_reg.state)
      SPC_IDLE: begin
        if (regWrite) begin
          unique case (regAddr)
            SPC_OFS_SETUP: begin
              if (regWrData[SPC_BIT_SOFTRST]) begin
                // soft reset returns every register to its reset value
                r_next = '0;
                r_next.state = SPC_RESET;
                r_next.rstPulse = 1'b1;
              end else begin
                // setup bits act at once, reserved bits dropped
                r_next.fourWire = regWrData[SPC_BIT_FOURWIRE];
                r_next.lsbFirst = regWrData[SPC_BIT_LSBFIRST];
              end
            end
            SPC_OFS_RBSEL: r_next.rbSel = regWrData[SPC_BIT_RBSEL];
            SPC_OFS_COMMIT: begin
              // one-step copy; the strobe is never stored
              if (regWrData[SPC_BIT_COMMIT]) begin
                r_next.scrAct = r_reg.scrBuf;
                r_next.revAct = REVISION;
                r_next.famAct = FAMILY_CODE;
              end
            end
            SPC_OFS_SCR_LO: r_next.scrBuf[7:0] = regWrData;
            SPC_OFS_SCR_HI: r_next.scrBuf[15:8] = regWrData;
            default: begin
              // revision and family writes ignored
            end
          endcase
        end
        if (regRead) begin
          scrView = r_reg.rbSel ? r_reg.scrBuf : r_reg.scrAct;
          r_next.rdValid = 1'b1;
          unique case (regAddr)
            SPC_OFS_SETUP:  r_next.rdData = setupByte(r_reg.fourWire, r_reg.lsbFirst);
            SPC_OFS_RBSEL:  r_next.rdData = lowBit(r_reg.rbSel);
            SPC_OFS_COMMIT: r_next.rdData = SPC_RST_ZERO;
            SPC_OFS_SCR_LO: r_next.rdData = scrView[7:0];
            SPC_OFS_SCR_HI: r_next.rdData = scrView[15:8];
            SPC_OFS_REV:    r_next.rdData = r_reg.revAct;
            SPC_OFS_FAM_LO: r_next.rdData = r_reg.famAct[7:0];
            SPC_OFS_FAM_HI: r_next.rdData = r_reg.famAct[15:8];
            default:        r_next.rdData = SPC_RST_ZERO;
          endcase
        end
        if (nvSave) begin
          // save stream carries scratch only, never the setup byte
          r_next.nvValid = 1'b1;
          unique case (regAddr)
            SPC_OFS_SCR_LO: r_next.nvData = r_reg.scrAct[7:0];
            SPC_OFS_SCR_HI: r_next.nvData = r_reg.scrAct[15:8];
            default:        r_next.nvData = SPC_RST_ZERO;
          endcase
        end
      end
      SPC_RESET: begin
        // reload only when a stored configuration is enabled
        r_next.revAct = REVISION;
        r_next.famAct = FAMILY_CODE;
        if (reloadEnable) begin
          r_next.reloadGo = 1'b1;
          r_next.state = SPC_RELOAD;
        end else begin
          r_next.state = SPC_IDLE;
        end
      end
      SPC_RELOAD: begin
        // port stays deaf until the download finishes
        if (reloadDone) r_next.state = SPC_IDLE;
      end
      default: r_next.state = SPC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      r_reg <= '0;
      r_reg.state <= SPC_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdData      = r_reg.rdData;
  assign regRdValid     = r_reg.rdValid;
  assign nvSaveData     = r_reg.nvData;
  assign nvSaveValid    = r_reg.nvValid;
  assign fourWireSelect = r_reg.fourWire;
  assign lsbFirst       = r_reg.lsbFirst;
  assign addrIncrement  = r_reg.lsbFirst;
  assign softResetPulse = r_reg.rstPulse;
  assign reloadStart    = r_reg.reloadGo;
  assign reloadBusy     = (r_reg.state != SPC_IDLE);
  assign scratchActive  = r_reg.scrAct;

endmodule
`default_nettype wire

/* inc/spc_pkg.sv */
package spc_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SPC_OFS_SETUP    = 8'h00;
  localparam logic [7:0] SPC_OFS_RBSEL    = 8'h04;
  localparam logic [7:0] SPC_OFS_COMMIT   = 8'h05;
  localparam logic [7:0] SPC_OFS_SCR_LO   = 8'h06;
  localparam logic [7:0] SPC_OFS_SCR_HI   = 8'h07;
  localparam logic [7:0] SPC_OFS_REV      = 8'h0a;
  localparam logic [7:0] SPC_OFS_FAM_LO   = 8'h0c;
  localparam logic [7:0] SPC_OFS_FAM_HI   = 8'h0d;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SPC_BIT_FOURWIRE = 7;
  localparam int SPC_BIT_LSBFIRST = 6;
  localparam int SPC_BIT_SOFTRST  = 5;
  localparam int SPC_BIT_RBSEL    = 0;
  localparam int SPC_BIT_COMMIT   = 0;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SPC_RST_SETUP   = 8'h00;
  localparam logic       SPC_RST_RBSEL   = 1'b0;
  localparam logic [7:0] SPC_RST_SCRATCH = 8'h00;
  localparam logic [7:0] SPC_RST_ZERO    = 8'h00;
  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPC_IDLE   = 2'b00,
    SPC_RESET  = 2'b01,
    SPC_RELOAD = 2'b10
  } spc_state_t;
endpackage

/* verif/spc_loader_model.sv */
`timescale 1ns/10ps
`default_nettype none
module spc_loader_model (
  input  wire logic clk,
  input  wire logic slow,
  input  wire logic reloadStart,
  output logic      reloadDone
);
  logic [3:0] cnt = 4'h0;
  // slow mode stretches the stored-image download
  always_ff @(posedge clk) begin
    if (reloadStart) cnt <= slow ? 4'h9 : 4'h1;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  assign reloadDone = cnt == 4'h1 && !reloadStart;
endmodule
`default_nettype wire

/* verif/spc_config_regs_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module spc_config_regs_sva
  import spc_pkg::*;
#(
  parameter logic [7:0]  REVISION    = 8'h5a,  // arbitrary value
  parameter logic [15:0] FAMILY_CODE = 16'hc3e7 // arbitrary value
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic        reloadEnable,
  input wire logic        reloadDone,
  input wire logic        nvSave,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData,
  input wire logic [7:0]  nvSaveData,
  input wire logic        regRdValid,
  input wire logic        nvSaveValid,
  input wire logic        fourWireSelect,
  input wire logic        lsbFirst,
  input wire logic        addrIncrement,
  input wire logic        softResetPulse,
  input wire logic        reloadStart,
  input wire logic        reloadBusy,
  input wire logic [15:0] scratchActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire w       = regWrite && !reloadBusy;
  wire r       = regRead && !reloadBusy;
  wire setupWr = w && regAddr == SPC_OFS_SETUP && !regWrData[SPC_BIT_SOFTRST];
  sequence s_soft; w && regAddr == SPC_OFS_SETUP && regWrData[SPC_BIT_SOFTRST]; endsequence
  sequence s_load; softResetPulse && reloadBusy ##1 reloadStart == $past(reloadEnable); endsequence
  property p_soft; s_soft |=> s_load; endproperty
  a_soft: assert property (p_soft) else $error("soft reset order");
  property p_wire;
    setupWr |=> fourWireSelect == $past(regWrData[SPC_BIT_FOURWIRE]);
  endproperty
  a_wire: assert property (p_wire) else $error("wiring select");
  property p_ord;
    setupWr |=> lsbFirst == $past(regWrData[SPC_BIT_LSBFIRST]) && addrIncrement == lsbFirst;
  endproperty
  a_ord: assert property (p_ord) else $error("bit order");
  property p_dir;
    setupWr && !regWrData[SPC_BIT_LSBFIRST] |=> !lsbFirst && !addrIncrement;
  endproperty
  a_dir: assert property (p_dir) else $error("address direction");
  property p_rev; r && regAddr == SPC_OFS_REV |=> regRdValid && regRdData == REVISION; endproperty
  a_rev: assert property (p_rev) else $error("revision read");
  property p_fam; r && regAddr == SPC_OFS_FAM_HI |=> regRdData == FAMILY_CODE[15:8]; endproperty
  a_fam: assert property (p_fam) else $error("family read");
  property p_clr; r && regAddr == SPC_OFS_COMMIT |=> regRdData == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("commit reads set");
  property p_hold;
    !(w && (regAddr == SPC_OFS_COMMIT || regAddr == SPC_OFS_SETUP)) |=> $stable(scratchActive);
  endproperty
  a_hold: assert property (p_hold) else $error("active moved");
  property p_nv;
    nvSave && !reloadBusy && regAddr == SPC_OFS_SETUP |=> nvSaveValid && nvSaveData == 8'h00;
  endproperty
  a_nv: assert property (p_nv) else $error("setup saved");
  property p_rsv; r && regAddr == SPC_OFS_RBSEL |=> regRdData[7:1] == 7'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
endmodule
bind spc_config_regs spc_config_regs_sva #(
  .REVISION    (REVISION),
  .FAMILY_CODE (FAMILY_CODE)
) i_sva (.*);
`default_nettype wire

/* verif/serial_port_config_regs_test.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_port_config_regs_test
  import spc_pkg::*;
  ;
  logic clk = 0, rst_b = 0, regWrite = 0, regRead = 0, reloadEnable = 0, nvSave = 0, slow = 0;
  logic regRdValid, nvSaveValid, reloadDone, reloadStart, fourWireSelect, lsbFirst;
  logic addrIncrement, softResetPulse, reloadBusy;
  logic [7:0]  regAddr = 0, regWrData = 0, regRdData, nvSaveData, q[$];
  logic [15:0] scratchActive, v = 16'd9651, act = 0;
  int fail_count = 0, cmp_count = 0;
  always #4 clk = ~clk;
  spc_config_regs i_dut (.*);
  spc_loader_model i_ldr (.*);
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  task automatic op(input logic wr, input logic rd, input logic [7:0] a, d, e);
    @(posedge clk);
    regWrite <= wr;
    regRead <= rd;
    regAddr <= a;
    regWrData <= d;
    if (rd) q.push_back(e);
  endtask
  task automatic settle;
    int n;
    for (n = 0; n < 60 && reloadBusy !== 1'b0; n++) @(negedge clk);
    cmp(reloadBusy, 0);
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(negedge clk) if (regRdValid === 1'b1) cmp(regRdData, q.size() ? q.pop_front() : 9'h100);
  initial begin
    #20000;
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1;
    repeat (3) @(negedge clk);
    settle();
    op(0, 1, SPC_OFS_SETUP, 0, 0);
    op(0, 1, SPC_OFS_SCR_HI, 0, 0);
    op(0, 1, SPC_OFS_FAM_LO, 0, 8'he7);
    op(0, 1, SPC_OFS_FAM_HI, 0, 8'hc3);
    op(0, 1, 8'h20, 0, 0);
    op(1, 0, SPC_OFS_SETUP, 8'hdf, 0);
    op(0, 1, SPC_OFS_SETUP, 0, 8'hc0);
    op(0, 0, 0, 0, 0);
    @(negedge clk);
    cmp({fourWireSelect, lsbFirst, addrIncrement}, 3'h7);
    op(1, 0, SPC_OFS_SETUP, 8'h80, 0);
    op(0, 0, 0, 0, 0);
    @(negedge clk);
    cmp({fourWireSelect, lsbFirst, addrIncrement}, 3'h4);
    repeat (2) begin
      v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
      op(1, 0, SPC_OFS_SCR_LO, v[7:0], 0);
      op(1, 0, SPC_OFS_SCR_HI, v[15:8], 0);
      op(0, 1, SPC_OFS_SCR_LO, 0, act[7:0]);
      op(1, 0, SPC_OFS_RBSEL, 8'hff, 0);
      op(0, 1, SPC_OFS_RBSEL, 0, 8'h01);
      op(0, 1, SPC_OFS_SCR_HI, 0, v[15:8]);
      op(1, 0, SPC_OFS_COMMIT, 8'h01, 0);
      op(0, 1, SPC_OFS_COMMIT, 0, 0);
      op(1, 0, SPC_OFS_RBSEL, 0, 0);
      op(0, 1, SPC_OFS_SCR_HI, 0, v[15:8]);
      op(0, 0, 0, 0, 0);
      act = v;
      @(negedge clk);
      cmp(scratchActive, act);
    end
    op(1, 0, SPC_OFS_REV, 8'h00, 0);
    op(0, 1, SPC_OFS_REV, 0, 8'h5a);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      nvSave <= 1;
      regAddr <= i ? SPC_OFS_SCR_LO : SPC_OFS_SETUP;
      regRead <= 0;
      @(posedge clk);
      nvSave <= 0;
      @(negedge clk);
      cmp({nvSaveValid, nvSaveData}, {1'b1, i ? act[7:0] : 8'h00});
    end
    @(posedge clk);
    reloadEnable <= 1;
    slow <= 1;
    op(1, 0, SPC_OFS_SETUP, 8'he0, 0);
    op(0, 0, 0, 0, 0);
    @(negedge clk);
    cmp({softResetPulse, reloadBusy}, 2'h3);
    settle();
    op(0, 1, SPC_OFS_SETUP, 0, 0);
    op(0, 1, SPC_OFS_SCR_LO, 0, 0);
    op(0, 0, 0, 0, 0);
    repeat (3) @(negedge clk);
    cmp(16'(q.size()), 0);
    wrap_up();
  end
endmodule
`default_nettype wire
